/* File: logic/chgsc_regs.svh */
`ifndef CHGSC_REGS_SVH
`define CHGSC_REGS_SVH
// register offsets, byte-wide data
`define CHGSC_ADDR_CTRL      8'h00
`define CHGSC_ADDR_CURRENT   8'h01
`define CHGSC_ADDR_STATUS    8'h02
`define CHGSC_ADDR_EVENT     8'h03
// control register fields
`define CHGSC_CTRL_SUSPEND   0
`define CHGSC_CTRL_DROOP_EN  1
`define CHGSC_CTRL_TH_TYPE   2
`define CHGSC_CTRL_HOT_V_DIS 3
`define CHGSC_CTRL_COLD_V_DIS 4
`define CHGSC_CTRL_HOT_I_DIS 5
`define CHGSC_CTRL_COLD_I_DIS 6
`define CHGSC_CTRL_RESET     7'h04
`define CHGSC_CURRENT_RESET  4'h0
// current code decode
`define CHGSC_CODE_LAST_STEP 4'hA
`define CHGSC_STEPS_MAX      4'hC
`define CHGSC_SDP_TYPE       3'h0
// thermistor ratio thresholds in percent (full current, 4.2 v)
`define CHGSC_RATIO_FULL_10K 7'h20
`define CHGSC_RATIO_CV_10K   7'h34
`define CHGSC_RATIO_FULL_100K 7'h23
`define CHGSC_RATIO_CV_100K  7'h40
// times in ms and flash rates in hz
`define CHGSC_QUAL_MS        19
`define CHGSC_WAKE_MS        90
`define CHGSC_FAULT_FLASH_HZ 4
`define CHGSC_TEMP_FLASH_MS  1000
`define CHGSC_CLK_HZ         25000000
`define CHGSC_MS_CYCLES      (`CHGSC_CLK_HZ / 1000)
`endif

/* File: logic/chgsc_pkg.sv */
package chgsc_pkg;
	// charge sequencer states, one-hot
	typedef enum logic [5:0] {
		st_off   = 6'h01,
		st_pre   = 6'h02,
		st_fast  = 6'h04,
		st_done  = 6'h08,
		st_rechg = 6'h10,
		st_fault = 6'h20
	} chgsc_state_t;
	// analog comparator results, already synchronous
	typedef struct packed {
		logic vin_above_cell_os;  // adapter above cell plus upper offset
		logic vin_above_ovp;      // adapter above overvoltage trip
		logic adapter_present;    // adapter above under-voltage lockout
		logic cell_present;
		logic cell_above_pre;     // cell out of pre-charge range
		logic term_current;       // deglitched termination condition
		logic cell_below_rechg;   // deglitched recharge condition
		logic ts_fault;           // thermistor_sense out of range
		logic cold_band;          // 0 to 10 c
		logic hot_band;           // 45 to 60 c
		logic power_path_sharing;
		logic supplementing;
		logic supp_short;
		logic die_above_tsd;
		logic die_below_hyst;
	} chgsc_sense_t;
	// temperature adjustments toward the regulators
	typedef struct packed {
		logic       cv_adjust;
		logic       cc_halve;
		logic [6:0] ratio_full;
		logic [6:0] ratio_cv;
	} chgsc_temp_t;
endpackage

/* File: logic/chgsc_timebase.sv */
`timescale 1ns/10ps
`include "chgsc_regs.svh"
// free-running millisecond enable, one pulse per period
module chgsc_timebase #(
	parameter int unsigned MS_CYCLES = `CHGSC_MS_CYCLES
) (
	input  wire logic mclk_in,
	input  wire logic rst_in,
	output logic      ms_tick_out
);
	typedef struct packed {
		logic [15:0] cnt;  // cycles within the millisecond
		logic        tick;
	} chgsc_tb_t;
	chgsc_tb_t tb_r;
	chgsc_tb_t tb_nxt;

	// count down, reload and pulse at zero
	always_comb begin
		tb_nxt = tb_r;
		tb_nxt.tick = 1'b0;
		if (tb_r.cnt == 16'h0000) begin
			tb_nxt.cnt = 16'(MS_CYCLES - 1);
			tb_nxt.tick = 1'b1;
		end else begin
			tb_nxt.cnt = tb_r.cnt - 16'h0001;
		end
	end

	// registered copy of the state
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			tb_r <= '0;
		end else begin
			tb_r <= tb_nxt;
		end
	end

	assign ms_tick_out = tb_r.tick;
endmodule

/* File: logic/chgsc_top.sv */
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`include "chgsc_regs.svh"
// What this block does
// - power good only between cell offset and overvoltage
// - end of charge sets done and event
// - done held through recharge, cleared charging
// - 19 ms qualified plug-in gives 90 ms pulse
// - no wake pulse while power section on
// - started wake pulse always runs full width
// - suspend bit stops charging
// - suspend releases charge state pin
// - current code decodes 0.1 a steps, cap 1.2
// - fast too long: flash 4 hz, trickle
// - fault cleared by replug, toggles, removal, overvoltage
// - fault limit inversely scales with current
// - hot or cold halves current, doubles limit
// - voltage target adjusted in bands, disable bits
// - current target adjusted in bands, disable bits
// - thermistor fault pauses charging, freezes timer
// - thermistor back in range resumes count
// - thermistor pause flashes pin at 0.5 hz
// - ratio thresholds chosen by thermistor type
// - droop guard forced on for sdp port
// - power path sharing inhibits termination
// - supplementing inhibits termination
// - short recovery wait then counter restart
// - die overheat opens input switch, hysteresis
// - status toggles, except the input switch bit, set sticky event, write zero clears
module chgsc_top #(
	parameter int unsigned MS_CYCLES   = `CHGSC_MS_CYCLES,
	parameter int unsigned FAULT_MS    = 18000, // fault time at full 1.2 a
	parameter int unsigned SHORT_REC_MS = 64     // supplement short recovery time
) (
	input  wire logic                  mclk_in,
	input  wire logic                  rst_in,
	input  wire logic [7:0]            reg_addr_in,
	input  wire logic [7:0]            reg_wdata_in,
	input  wire logic                  reg_wr_in,
	input  wire logic                  reg_rd_in,
	output logic      [7:0]            reg_rdata_out,
	input  wire chgsc_pkg::chgsc_sense_t sense_in,
	input  wire logic                  pmu_on_in,
	input  wire logic [2:0]            charger_port_type_in,
	output logic                       charge_enable_out,
	output logic                       trickle_out,
	output logic      [4:0]            current_target_out,
	output chgsc_pkg::chgsc_temp_t     temp_adjust_out,
	output logic                       input_droop_guard_out,
	output logic                       plug_in_pulse_out,
	output logic                       charge_state_pin_out,
	output logic                       charge_state_pin_oe_n_out,
	output logic                       load_rail_enable_out,
	output logic                       short_count_restart_out,
	output logic                       input_switch_on_out,
	output logic                       cell_switch_on_out
);
	localparam int unsigned FAST_HALF_MS = 1000 / (2 * `CHGSC_FAULT_FLASH_HZ);
	localparam int unsigned SLOW_HALF_MS = `CHGSC_TEMP_FLASH_MS;
	localparam int unsigned FAULT_UNITS  = FAULT_MS * 12; // limit in step-ms

	typedef struct packed {
		chgsc_pkg::chgsc_state_t st;
		logic [31:0] tmr;        // accumulated current steps times ms
		logic [7:0]  qual_cnt;   // plug-in stability count
		logic        qual_act;
		logic [7:0]  wake_cnt;   // remaining pulse ms
		logic        wake;
		logic [9:0]  flash_cnt;  // half-period count of indicator
		logic        flash_lvl;
		logic [15:0] short_cnt;  // recovery countdown
		logic        short_act;
		logic        restart;
		logic        sw_open;    // input switch open after overheat
		logic [6:0]  ctrl;
		logic [3:0]  code;
		logic        event_flag;
		logic        pg;
		logic        done_q;
		logic        tsf_q;
		logic        fault_q;
		logic        droop_q;
		logic        cell_q;
		logic        adp_q;
		logic        pmu_q;
		logic        ovp_q;
		logic [7:0]  rdata;
	} chgsc_core_t;

	chgsc_core_t s_r;
	chgsc_core_t s_nxt;
	logic        ms_tick;    // one-cycle millisecond enable
	logic        pg_now;     // present power-good encoding
	logic        done_now;   // charge complete indication
	logic        fault_now;
	logic        droop_now;
	logic        enable_now; // charging allowed by supply and software
	logic        susp_chg;   // suspend bit changing this cycle
	logic        clr_fault;
	logic        wr_ctrl;
	logic        wr_evt;
	logic [3:0]  steps;      // decoded current in 0.1 a steps
	logic        halve;

	chgsc_timebase #(
		.MS_CYCLES(MS_CYCLES)
	) u_tb (
		.mclk_in    (mclk_in),
		.rst_in     (rst_in),
		.ms_tick_out(ms_tick)
	);

	// current code to 0.1 a steps
	function automatic logic [3:0] chgsc_steps(input logic [3:0] code);
		if (code <= `CHGSC_CODE_LAST_STEP) begin
			chgsc_steps = code + 4'h1;
		end else begin
			chgsc_steps = `CHGSC_STEPS_MAX;
		end
	endfunction

	// band adjustment gated by its own disable bits
	function automatic logic chgsc_band(input logic hot, input logic cold,
			input logic hot_dis, input logic cold_dis);
		chgsc_band = (hot & ~hot_dis) | (cold & ~cold_dis);
	endfunction

	// combinational decode shared by state update and outputs
	always_comb begin
		pg_now = sense_in.vin_above_cell_os & ~sense_in.vin_above_ovp;
		done_now = (s_r.st == chgsc_pkg::st_done) | (s_r.st == chgsc_pkg::st_rechg);
		fault_now = (s_r.st == chgsc_pkg::st_fault);
		droop_now = (charger_port_type_in == `CHGSC_SDP_TYPE) |
			s_r.ctrl[`CHGSC_CTRL_DROOP_EN];
		wr_ctrl = reg_wr_in & (reg_addr_in == `CHGSC_ADDR_CTRL);
		wr_evt = reg_wr_in & (reg_addr_in == `CHGSC_ADDR_EVENT);
		susp_chg = wr_ctrl &
			(reg_wdata_in[`CHGSC_CTRL_SUSPEND] != s_r.ctrl[`CHGSC_CTRL_SUSPEND]);
		// replug, enable toggle, suspend change, removal, overvoltage
		clr_fault = (pg_now & ~s_r.pg) | (pmu_on_in != s_r.pmu_q) | susp_chg |
			(~sense_in.cell_present & s_r.cell_q) |
			(sense_in.vin_above_ovp & ~s_r.ovp_q);
		enable_now = pg_now & sense_in.cell_present &
			~s_r.ctrl[`CHGSC_CTRL_SUSPEND];
		steps = chgsc_steps(s_r.code);
		halve = chgsc_band(sense_in.hot_band, sense_in.cold_band,
			s_r.ctrl[`CHGSC_CTRL_HOT_I_DIS], s_r.ctrl[`CHGSC_CTRL_COLD_I_DIS]);
	end

	// next state of the whole block
	always_comb begin
		s_nxt = s_r;
		s_nxt.restart = 1'b0;
		// history for edge detection
		s_nxt.pg = pg_now;
		s_nxt.done_q = done_now;
		s_nxt.tsf_q = sense_in.ts_fault;
		s_nxt.fault_q = fault_now;
		s_nxt.droop_q = droop_now;
		s_nxt.cell_q = sense_in.cell_present;
		s_nxt.adp_q = sense_in.adapter_present;
		s_nxt.pmu_q = pmu_on_in;
		s_nxt.ovp_q = sense_in.vin_above_ovp;
		// register writes
		if (wr_ctrl) begin
			s_nxt.ctrl = reg_wdata_in[6:0];
		end
		if (reg_wr_in & (reg_addr_in == `CHGSC_ADDR_CURRENT)) begin
			s_nxt.code = reg_wdata_in[3:0];
		end
		// write zero clears, a new event in the same cycle wins
		if (wr_evt & ~reg_wdata_in[0]) begin
			s_nxt.event_flag = 1'b0;
		end
		if ((pg_now != s_r.pg) | (done_now != s_r.done_q) |
				(sense_in.ts_fault != s_r.tsf_q) | (fault_now != s_r.fault_q) |
				(droop_now != s_r.droop_q) | (sense_in.cell_present != s_r.cell_q)) begin
			s_nxt.event_flag = 1'b1;
		end
		// read data stand in the cycle after the strobe only
		s_nxt.rdata = 8'h00;
		if (reg_rd_in) begin
			case (reg_addr_in)
				`CHGSC_ADDR_CTRL: s_nxt.rdata = {1'b0, s_r.ctrl};
				`CHGSC_ADDR_CURRENT: s_nxt.rdata = {4'h0, s_r.code};
				`CHGSC_ADDR_STATUS: s_nxt.rdata = {~s_r.sw_open, s_r.cell_q,
					s_r.droop_q, s_r.tsf_q, s_r.fault_q, s_r.event_flag,
					s_r.done_q, s_r.pg};
				`CHGSC_ADDR_EVENT: s_nxt.rdata = {7'h00, s_r.event_flag};
				default: s_nxt.rdata = 8'h00; // unmapped reads zero
			endcase
		end
		// charge sequencer
		case (s_r.st)
			chgsc_pkg::st_off: begin
				if (enable_now & ~sense_in.ts_fault) begin
					s_nxt.st = chgsc_pkg::st_pre;
				end
			end
			chgsc_pkg::st_pre: begin
				if (sense_in.cell_above_pre & ~sense_in.ts_fault) begin
					s_nxt.st = chgsc_pkg::st_fast;
					s_nxt.tmr = 32'h0000_0000;
				end
			end
			chgsc_pkg::st_fast: begin
				// thermistor fault holds the count unchanged
				if (ms_tick & ~sense_in.ts_fault) begin
					s_nxt.tmr = s_r.tmr + {28'h0, steps};
				end
				if (s_r.tmr >= (halve ? 32'(FAULT_UNITS * 2) : 32'(FAULT_UNITS))) begin
					s_nxt.st = chgsc_pkg::st_fault;
				end else if (sense_in.term_current & ~sense_in.power_path_sharing &
						~sense_in.supplementing & ~sense_in.ts_fault) begin
					s_nxt.st = chgsc_pkg::st_done;
				end
			end
			chgsc_pkg::st_done: begin
				if (sense_in.cell_below_rechg) begin
					s_nxt.st = chgsc_pkg::st_rechg;
				end
			end
			chgsc_pkg::st_rechg: begin
				if (sense_in.term_current & ~sense_in.power_path_sharing &
						~sense_in.supplementing) begin
					s_nxt.st = chgsc_pkg::st_done;
				end
			end
			chgsc_pkg::st_fault: begin
				if (clr_fault) begin
					s_nxt.st = chgsc_pkg::st_off;
				end
			end
			default: s_nxt.st = chgsc_pkg::st_off;
		endcase
		// losing supply or suspending ends any cycle but a latched fault
		if (~enable_now & ~fault_now) begin
			s_nxt.st = chgsc_pkg::st_off;
		end else if (fault_now & clr_fault) begin
			s_nxt.st = chgsc_pkg::st_off;
		end
		// plug-in qualification, restarted on every fresh insertion
		if ((sense_in.cell_present & ~s_r.cell_q) |
				(sense_in.adapter_present & ~s_r.adp_q)) begin
			s_nxt.qual_act = 1'b1;
			s_nxt.qual_cnt = 8'(`CHGSC_QUAL_MS);
		end else if (s_r.qual_act) begin
			if (~sense_in.cell_present & ~sense_in.adapter_present) begin
				s_nxt.qual_act = 1'b0; // glitch, drop it
			end else if (ms_tick) begin
				if (s_r.qual_cnt == 8'h01) begin
					s_nxt.qual_act = 1'b0;
					// masked while power section on; pulse is never cut
					if (~pmu_on_in & ~s_r.wake) begin
						s_nxt.wake = 1'b1;
						s_nxt.wake_cnt = 8'(`CHGSC_WAKE_MS);
					end
				end else begin
					s_nxt.qual_cnt = s_r.qual_cnt - 8'h01;
				end
			end
		end
		if (s_r.wake & ms_tick) begin
			if (s_r.wake_cnt == 8'h01) begin
				s_nxt.wake = 1'b0;
			end
			s_nxt.wake_cnt = s_r.wake_cnt - 8'h01;
		end
		// indicator flash divider, restarted on leaving flash states
		if (~fault_now & ~sense_in.ts_fault) begin
			s_nxt.flash_cnt = 10'h000;
			s_nxt.flash_lvl = 1'b0;
		end else if (ms_tick) begin
			if (s_r.flash_cnt >= 10'((fault_now ? FAST_HALF_MS : SLOW_HALF_MS) - 1)) begin
				s_nxt.flash_cnt = 10'h000;
				s_nxt.flash_lvl = ~s_r.flash_lvl;
			end else begin
				s_nxt.flash_cnt = s_r.flash_cnt + 10'h001;
			end
		end
		// supplement short: disable load rail, wait, then restart counter
		if (s_r.short_act) begin
			if (ms_tick) begin
				if (s_r.short_cnt == 16'h0001) begin
					s_nxt.short_act = 1'b0;
					s_nxt.restart = 1'b1;
				end
				s_nxt.short_cnt = s_r.short_cnt - 16'h0001;
			end
		end else if (sense_in.supplementing & sense_in.supp_short) begin
			s_nxt.short_act = 1'b1;
			s_nxt.short_cnt = 16'(SHORT_REC_MS);
		end
		// die overheat with hysteresis
		if (sense_in.die_above_tsd) begin
			s_nxt.sw_open = 1'b1;
		end else if (s_r.sw_open & sense_in.die_below_hyst) begin
			s_nxt.sw_open = 1'b0;
		end
	end

	// single state register
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			s_r <= '0;
			s_r.st <= chgsc_pkg::st_off;
			s_r.ctrl <= `CHGSC_CTRL_RESET;
			s_r.code <= `CHGSC_CURRENT_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end

	// outputs toward the analog section and pins
	always_comb begin
		reg_rdata_out = s_r.rdata;
		charge_enable_out = (s_r.st == chgsc_pkg::st_pre) | (s_r.st == chgsc_pkg::st_fast) |
			(s_r.st == chgsc_pkg::st_rechg);
		// suspend cuts charging at once, not one sequencer step later
		charge_enable_out = charge_enable_out & ~sense_in.ts_fault &
			~s_r.ctrl[`CHGSC_CTRL_SUSPEND];
		trickle_out = fault_now;
		current_target_out = halve ? {1'b0, steps} : {steps, 1'b0};
		temp_adjust_out.cv_adjust = chgsc_band(sense_in.hot_band, sense_in.cold_band,
			s_r.ctrl[`CHGSC_CTRL_HOT_V_DIS], s_r.ctrl[`CHGSC_CTRL_COLD_V_DIS]);
		temp_adjust_out.cc_halve = halve;
		temp_adjust_out.ratio_full = s_r.ctrl[`CHGSC_CTRL_TH_TYPE] ?
			`CHGSC_RATIO_FULL_100K : `CHGSC_RATIO_FULL_10K;
		temp_adjust_out.ratio_cv = s_r.ctrl[`CHGSC_CTRL_TH_TYPE] ?
			`CHGSC_RATIO_CV_100K : `CHGSC_RATIO_CV_10K;
		input_droop_guard_out = s_r.droop_q;
		plug_in_pulse_out = s_r.wake;
		charge_state_pin_out = 1'b0; // open drain, only ever pulls low
		// low means charging; flash in fault or thermistor pause
		if (s_r.ctrl[`CHGSC_CTRL_SUSPEND]) begin
			charge_state_pin_oe_n_out = 1'b1;
		end else if (fault_now | (sense_in.ts_fault & (s_r.st != chgsc_pkg::st_off))) begin
			charge_state_pin_oe_n_out = s_r.flash_lvl;
		end else begin
			charge_state_pin_oe_n_out = ~charge_enable_out;
		end
		load_rail_enable_out = ~s_r.short_act;
		short_count_restart_out = s_r.restart;
		input_switch_on_out = ~s_r.sw_open;
		cell_switch_on_out = 1'b1; // cell keeps feeding the load
	end

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (rst_in);

	// helper: ms ticks seen while the wake pulse is high
	logic [7:0] wake_w;
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			wake_w <= 8'h00;
		end else if (!s_r.wake) begin
			wake_w <= 8'h00;
		end else if (ms_tick) begin
			wake_w <= wake_w + 8'h01;
		end
	end

	sequence pulse_end_s;
		$fell(plug_in_pulse_out);
	endsequence

	pg_encode_a: assert property ($past(sense_in.vin_above_ovp) |-> !s_r.pg)
		else $error("power good set above overvoltage");
	done_event_a: assert property ($rose(s_r.done_q) |-> s_r.event_flag)
		else $error("done without pending event");
	done_hold_a: assert property (s_r.st == chgsc_pkg::st_rechg |=> s_r.done_q)
		else $error("done flag dropped in recharge");
	wake_width_a: assert property (pulse_end_s |-> wake_w == 8'(`CHGSC_WAKE_MS))
		else $error("wake pulse width not 90 ms");
	wake_mask_a: assert property ($rose(plug_in_pulse_out) |-> !$past(pmu_on_in))
		else $error("wake pulse while power section on");
	wake_hold_a: assert property (plug_in_pulse_out && s_r.wake_cnt > 8'h01
			|=> plug_in_pulse_out)
		else $error("wake pulse cut short");
	suspend_release_a: assert property (s_r.ctrl[0] |-> charge_state_pin_oe_n_out
			&& !charge_enable_out)
		else $error("pin driven or charging in suspend");
	droop_sdp_a: assert property (charger_port_type_in == `CHGSC_SDP_TYPE
			|=> input_droop_guard_out)
		else $error("droop guard off on sdp port");
	timer_pause_a: assert property (s_r.st == chgsc_pkg::st_fast && sense_in.ts_fault
			&& $past(s_r.st) == chgsc_pkg::st_fast |=> s_r.tmr == $past(s_r.tmr))
		else $error("fault timer moved while paused");
	event_clear_a: assert property (wr_evt && !reg_wdata_in[0] && s_r.event_flag
			&& !(pg_now != s_r.pg) && !(done_now != s_r.done_q)
			&& !(sense_in.ts_fault != s_r.tsf_q) && !(fault_now != s_r.fault_q)
			&& !(droop_now != s_r.droop_q) && !(sense_in.cell_present != s_r.cell_q)
			|=> !s_r.event_flag)
		else $error("event flag not cleared");
	fault_trickle_a: assert property (s_r.st == chgsc_pkg::st_fault |-> trickle_out
			&& !charge_enable_out)
		else $error("fault without trickle");
endmodule

/* File: testbench/chgsc_host.sv */
`timescale 1ns/10ps
// host software side: register bus master and the power section enable pin
module chgsc_host (
	input  wire logic       mclk_in,
	input  wire logic [7:0] rdata_in,
	output logic      [7:0] addr_out,
	output logic      [7:0] wdata_out,
	output logic            wr_out,
	output logic            rd_out,
	output logic            pmu_on_out
);
	// idle bus at time zero
	initial begin
		addr_out = 8'h00;
		wdata_out = 8'h00;
		wr_out = 1'b0;
		rd_out = 1'b0;
		pmu_on_out = 1'b0;
	end
	// one-cycle write; stale data inverted after so nothing leans on it
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		addr_out <= a;
		wdata_out <= d;
		wr_out <= 1'b1;
		@(posedge mclk_in);
		wr_out <= 1'b0;
		wdata_out <= ~d;
		@(posedge mclk_in);
	endtask
	// one-cycle read; data only valid in the following cycle
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		addr_out <= a;
		rd_out <= 1'b1;
		@(posedge mclk_in);
		rd_out <= 1'b0;
		@(negedge mclk_in);
		d = rdata_in;
		@(posedge mclk_in);
	endtask
	// level change of the enable pin, a toggle also releases a fault
	task automatic pmu(input logic v);
		pmu_on_out <= v;
	endtask
endmodule

/* File: testbench/chgsc_tb_top.sv */
`timescale 1ns/10ps
// bench: 4 cycles per ms keeps every ms count short
module chgsc_tb_top;
	localparam int           MSC = 4;
	logic                    mclk_in = 1'b0;
	logic                    rst_in = 1'b1;
	chgsc_pkg::chgsc_sense_t sense = '0;  // analog comparator levels
	logic [2:0]              port = 3'h1;  // not a standard port
	logic [7:0]              addr, wdata, rdata, rv;
	logic                    wr, rd, pmu, cen, trk, oen, wake, drp, isw, csw, csp, lre, scr;
	logic [4:0]              cur;
	chgsc_pkg::chgsc_temp_t  tadj;
	int                      err_total = 0;
	int                      num_checks = 0;
	// free clock, 40 ns period
	always #20 mclk_in = ~mclk_in;
	chgsc_host i_host (.mclk_in(mclk_in), .rdata_in(rdata), .addr_out(addr),
		.wdata_out(wdata), .wr_out(wr), .rd_out(rd), .pmu_on_out(pmu));
	chgsc_top #(.MS_CYCLES(MSC), .FAULT_MS(2), .SHORT_REC_MS(3)) i_dut (
		.mclk_in(mclk_in), .rst_in(rst_in), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_rdata_out(rdata), .sense_in(sense), .pmu_on_in(pmu),
		.charger_port_type_in(port), .charge_enable_out(cen), .trickle_out(trk),
		.current_target_out(cur), .temp_adjust_out(tadj),
		.input_droop_guard_out(drp), .plug_in_pulse_out(wake),
		.charge_state_pin_out(csp), .charge_state_pin_oe_n_out(oen),
		.load_rail_enable_out(lre), .short_count_restart_out(scr),
		.input_switch_on_out(isw), .cell_switch_on_out(csw));
	// verdict, reached from the main sequence or the watchdog
	task automatic test_done;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// single bit compare, case equality so x never matches
	task automatic chk_b(input logic g, input logic e);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH t=%0t bit %b exp %b", $time, g, e);
		end
	endtask
	// byte compare
	task automatic chk_v(input logic [7:0] g, input logic [7:0] e);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH t=%0t val %h exp %h", $time, g, e);
		end
	endtask
	task automatic tk(input int n);
		repeat (n) @(posedge mclk_in);
	endtask
	// masked register read against an expected value
	task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		i_host.rd(a, rv);
		chk_v(rv & m, e);
	endtask
	// bounded wait for the trickle flag, resyncs to the rising edge
	task automatic wtrk(input int n, input logic e);
		int k;
		k = 0;
		while (trk !== e && k < n) begin
			@(negedge mclk_in);
			k++;
		end
		chk_b(trk, e);
		@(posedge mclk_in);
	endtask
	task automatic pg(input logic os, input logic ov, input logic ad, input logic e);
		sense.vin_above_cell_os <= os;
		sense.vin_above_ovp <= ov;
		sense.adapter_present <= ad;
		tk(3);
		rchk(8'h02, 8'h01, {7'h00, e});
	endtask
	// reset values; an unmapped place reads zero
	task automatic s_reset;
		rchk(8'h00, 8'hFF, 8'h04);
		rchk(8'h01, 8'hFF, 8'h00);
		rchk(8'h05, 8'hFF, 8'h00);
	endtask
	// every code, then band halving and its disable bits
	task automatic s_cur;
		for (int c = 0; c < 16; c++) begin
			i_host.wr(8'h01, 8'(c));
			chk_v({3'h0, cur}, 8'(2 * ((c > 10) ? 12 : c + 1)));
		end
		sense.hot_band <= 1'b1;
		tk(2);
		chk_v({3'h0, cur}, 8'h0C);
		chk_b(tadj.cv_adjust, 1'b1);
		chk_v({1'b0, tadj.ratio_full}, 8'h23);
		chk_v({1'b0, tadj.ratio_cv}, 8'h40);
		i_host.wr(8'h00, 8'h28);
		chk_v({3'h0, cur}, 8'h18);
		chk_b(tadj.cv_adjust, 1'b0);
		chk_v({1'b0, tadj.ratio_full}, 8'h20);
		chk_v({1'b0, tadj.ratio_cv}, 8'h34);
		sense.hot_band <= 1'b0;
		// droop guard is registered one cycle behind the control write
		i_host.wr(8'h00, 8'h06);
		tk(1);
		chk_b(drp, 1'b1);
		i_host.wr(8'h00, 8'h04);
		tk(1);
		chk_b(drp, 1'b0);
		port <= 3'h0;
		tk(2);
		chk_b(drp, 1'b1);
		port <= 3'h1;
	endtask
	// qualified plug-in, full width despite enable, then masked
	task automatic s_wake;
		int n;
		int hi;
		logic seen;
		n = 0;
		hi = 0;
		seen = 1'b0;
		sense.cell_present <= 1'b1;
		while (wake !== 1'b1 && n < 30 * MSC) begin
			@(negedge mclk_in);
			n++;
		end
		chk_b(n >= 18 * MSC && n < 21 * MSC, 1'b1);
		do begin
			@(posedge mclk_in);
			if (hi == 8) begin
				i_host.pmu(1'b1);
			end
			@(negedge mclk_in);
			hi++;
		end while (wake === 1'b1 && hi < 100 * MSC);
		chk_b(hi == 90 * MSC, 1'b1);
		@(posedge mclk_in);
		sense.cell_present <= 1'b0;
		tk(4);
		sense.cell_present <= 1'b1;
		repeat (30 * MSC) begin
			@(negedge mclk_in);
			seen = seen | (wake === 1'b1);
		end
		chk_b(seen, 1'b0);
		@(posedge mclk_in);
	endtask
	// charge, termination inhibit, done, recharge, suspend
	task automatic s_flow;
		// power good rises during the code write, so the clear below stands alone
		sense.vin_above_cell_os <= 1'b1;
		sense.cell_above_pre <= 1'b1;
		sense.power_path_sharing <= 1'b1;
		i_host.wr(8'h01, 8'h00);
		i_host.wr(8'h03, 8'h00);
		rchk(8'h03, 8'h01, 8'h00);
		sense.term_current <= 1'b1;
		tk(4);
		rchk(8'h02, 8'h02, 8'h00);
		sense.power_path_sharing <= 1'b0;
		sense.supplementing <= 1'b1;
		tk(4);
		rchk(8'h02, 8'h02, 8'h00);
		sense.supplementing <= 1'b0;
		tk(4);
		rchk(8'h02, 8'h06, 8'h06);
		sense.term_current <= 1'b0;
		sense.cell_below_rechg <= 1'b1;
		tk(4);
		chk_b(cen, 1'b1);
		rchk(8'h02, 8'h02, 8'h02);
		sense.cell_below_rechg <= 1'b0;
		i_host.wr(8'h00, 8'h05);
		chk_b(cen, 1'b0);
		chk_b(oen, 1'b1);
		chk_b(csp, 1'b0);
	endtask
	// fault timeout, release by enable toggle, pause keeps the count
	task automatic s_fault;
		i_host.wr(8'h01, 8'h0B);
		i_host.wr(8'h00, 8'h04);
		wtrk(40, 1'b1);
		chk_b(oen, 1'b0);
		rchk(8'h02, 8'h08, 8'h08);
		// half period of the fault flash is 125 ms, 500 cycles here
		tk(510);
		chk_b(oen, 1'b1);
		i_host.wr(8'h01, 8'h00);
		i_host.pmu(1'b0);
		tk(4);
		chk_b(trk, 1'b0);
		tk(40);
		chk_b(trk, 1'b0);
		sense.ts_fault <= 1'b1;
		tk(4);
		chk_b(cen, 1'b0);
		chk_b(oen, 1'b0);
		// pause flash toggles after 1000 ms, 4000 cycles here
		tk(4010);
		chk_b(oen, 1'b1);
		chk_b(trk, 1'b0);
		sense.ts_fault <= 1'b0;
		wtrk(70, 1'b1);
		sense.die_above_tsd <= 1'b1;
		tk(3);
		chk_b(isw, 1'b0);
		chk_b(csw, 1'b1);
		sense.die_above_tsd <= 1'b0;
		sense.die_below_hyst <= 1'b1;
		tk(3);
		chk_b(isw, 1'b1);
	endtask
	// supplement short: load rail off for three ms, then one restart pulse
	task automatic s_short;
		int k;
		k = 0;
		sense.supplementing <= 1'b1;
		sense.supp_short <= 1'b1;
		tk(2);
		chk_b(lre, 1'b0);
		sense.supp_short <= 1'b0;
		while (scr !== 1'b1 && k < 20) begin
			@(negedge mclk_in);
			k++;
		end
		chk_b(k >= 8 && k <= 12, 1'b1);
		chk_b(lre, 1'b1);
		@(posedge mclk_in);
	endtask
	// main sequence after 12 cycles of reset
	initial begin
		repeat (12) @(posedge mclk_in);
		rst_in <= 1'b0;
		@(posedge mclk_in);
		s_reset;
		pg(1'b0, 1'b0, 1'b0, 1'b0);
		pg(1'b0, 1'b0, 1'b1, 1'b0);
		pg(1'b1, 1'b0, 1'b1, 1'b1);
		pg(1'b1, 1'b1, 1'b1, 1'b0);
		pg(1'b0, 1'b0, 1'b1, 1'b0);
		s_cur;
		s_wake;
		s_flow;
		s_fault;
		s_short;
		test_done;
	end
	// watchdog: nearly four times the expected run length
	initial begin
		repeat (20000) @(posedge mclk_in);
		err_total++;
		test_done;
	end
endmodule
